/* logic/reset_hibernate_sequencer.sv */
// Reset and hibernate sequencer of the processor
// Function
// (R1) Hibernate gates clocks and drops regulator wake
// (R2) Hibernate three-states pins unless exempted
// (R3) Regulator wake high means core power up
// (R4) Hardware reset in hibernate wakes, then boots
// (R5) Active reset holds registers default, units idle
// (R6) System reset release leaves core ready to boot
// (R7) Hardware reset clears everything incl. control unit
// (R8) System reset spares reset control unit
// (R9) Software issues core resets, keeps masters off
// (R10) Low hardware reset pin enters hardware reset
// (R11) System reset from software, hibernate, event sources; hibernate is not a source here, it is left only by hardware reset
// (R12) Software saves state before hibernate
// (R13) Software drains core transactions before core reset
// (R14) Sync hardware reset release, assert asynchronously
module reset_hibernate_sequencer
    import rst_seq_pkg::*;
#(
    parameter int unsigned PIN_W = 8
) (
    // Clock and hardware reset pin
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    // Reset control register access
    input  wire logic             ctl_wr_i,
    input  wire logic [CTL_W-1:0] ctl_wdata_i,
    output logic      [CTL_W-1:0] reset_ctrl_reg_o,
    // System reset requests and hibernate
    input  wire logic             hib_req_i,
    input  wire logic             sys_event_ctrl_req_i,
    input  wire logic             trigger_router_req_i,
    input  wire logic             emu_req_i,
    // Pin control
    input  wire logic [PIN_W-1:0] pin_keep_i,
    output logic      [PIN_W-1:0] pin_oe_allow_o,
    // Resets, clocks and regulator
    output logic                  sys_rst_n_o,
    output logic                  core_rst_n_o,
    output logic                  clk_en_o,
    output logic                  boot_start_o,
    output logic                  regulator_wake_o,
    output logic      [1:0]       last_cause_o
);
    logic             hw_reset_n;
    seq_state_t       state_r;
    seq_state_t       state_nxt;
    logic [HOLD_W-1:0] hold_r;
    logic [HOLD_W-1:0] hold_nxt;
    logic [CTL_W-1:0] ctl_r;
    logic [CTL_W-1:0] ctl_nxt;
    logic [1:0]       cause_r;
    logic [1:0]       cause_nxt;
    logic             wake_r;
    logic             wake_nxt;
    logic             sys_req;

    // (R14) synchronised hardware reset
    rst_sync u_rst_sync (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .rst_sync_n_o (hw_reset_n)
    );

    // (R11) system reset sources
    assign sys_req = (ctl_wr_i && ctl_wdata_i[CTL_SYS_BIT]) || sys_event_ctrl_req_i
                   || trigger_router_req_i || emu_req_i;

    always_comb begin
        state_nxt = state_r;
        hold_nxt  = hold_r;
        ctl_nxt   = ctl_r;
        cause_nxt = cause_r;
        wake_nxt  = wake_r;
        if (ctl_wr_i) begin
            ctl_nxt = ctl_wdata_i;
        end
        unique case (state_r)
            ST_HW_RST: begin
                wake_nxt = 1'b1;
                hold_nxt = hold_r + 4'h1;
                if (hold_r == HOLD_LAST) begin
                    hold_nxt  = HOLD_ZERO;
                    state_nxt = ST_BOOT;
                end
            end
            ST_SYS_RST: begin
                hold_nxt = hold_r + 4'h1;
                if (hold_r == HOLD_LAST) begin
                    hold_nxt  = HOLD_ZERO;
                    // (R6) release into boot
                    state_nxt = ST_BOOT;
                end
            end
            ST_BOOT: begin
                state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (hib_req_i) begin
                    // (R1) drop wake on hibernate
                    wake_nxt  = 1'b0;
                    cause_nxt = CAUSE_HIB;
                    state_nxt = ST_HIBERNATE;
                end else if (sys_req) begin
                    // (R8) control unit contents kept
                    cause_nxt = CAUSE_SYS;
                    hold_nxt  = HOLD_ZERO;
                    state_nxt = ST_SYS_RST;
                end
            end
            ST_HIBERNATE: begin
                wake_nxt = 1'b0;
            end
        endcase
    end

    // (R7) hardware reset clears all state
    always_ff @(posedge sys_clk_i or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            state_r <= ST_HW_RST;
            hold_r  <= HOLD_ZERO;
            ctl_r   <= CTL_RESET;
            cause_r <= CAUSE_HW;
            wake_r  <= 1'b1;
        end else begin
            state_r <= state_nxt;
            hold_r  <= hold_nxt;
            ctl_r   <= ctl_nxt;
            cause_r <= cause_nxt;
            wake_r  <= wake_nxt;
        end
    end

    // (R5) units held in reset while active
    assign sys_rst_n_o      = (state_r == ST_RUN) || (state_r == ST_BOOT);
    // (R9) core reset follows software bit
    assign core_rst_n_o     = sys_rst_n_o && !ctl_r[CTL_CORE_BIT];
    // (R1) clocks gated in hibernate
    assign clk_en_o         = (state_r != ST_HIBERNATE);
    assign boot_start_o     = (state_r == ST_BOOT);
    // (R3) (R4) wake active high, raised on hardware reset release
    assign regulator_wake_o = wake_r && hw_reset_n;
    // (R2) pins released in hibernate
    assign pin_oe_allow_o   = (state_r == ST_HIBERNATE) ? pin_keep_i : {PIN_W{1'b1}};
    assign reset_ctrl_reg_o = ctl_r;
    assign last_cause_o     = cause_r;

    // (R1) hibernate drops wake and clocks
    AST_HIB_OFF: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r == ST_RUN && hib_req_i) |=> (!regulator_wake_o && !clk_en_o)) // (R1)
        else $error("Hibernate entry left wake or clocks on");
    // (R1) clocks run outside hibernate
    AST_CLK_ON: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r != ST_HIBERNATE) |-> clk_en_o) // (R1)
        else $error("Clocks gated outside hibernate");
    // (R2) pins released in hibernate
    AST_HIB_PINS: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r == ST_HIBERNATE) |-> (pin_oe_allow_o == pin_keep_i)) // (R2)
        else $error("Pins not released in hibernate");
    // (R2) pins free outside hibernate
    AST_OE_RUN: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r != ST_HIBERNATE) |-> (pin_oe_allow_o == {PIN_W{1'b1}})) // (R2)
        else $error("Pins restricted outside hibernate");
    // (R3) wake high while running
    AST_WAKE_RUN: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r == ST_RUN) |-> regulator_wake_o) // (R3)
        else $error("Wake low while running");
    // (R4) only reset leaves hibernate
    AST_HIB_STAY: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r == ST_HIBERNATE) |=> (state_r == ST_HIBERNATE)) // (R4)
        else $error("Hibernate left without hardware reset");
    // (R4) wake rises on release
    AST_WAKE_REL: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        $rose(hw_reset_n) |-> regulator_wake_o) // (R4)
        else $error("Wake not raised on reset release");
    // (R4) boot follows reset release
    AST_HW_BOOT: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        ($rose(hw_reset_n) ##0 1'b1) |-> ##8 boot_start_o) // (R4)
        else $error("No boot after hardware reset release");
    // (R5) system reset hold length
    AST_SYS_HOLD: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r == ST_RUN && !hib_req_i && sys_req) |=> (!sys_rst_n_o)[*8] ##1 boot_start_o) // (R5)
        else $error("System reset hold wrong");
    // (R5) requests ignored during hold
    AST_SYS_REFUSE: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r == ST_SYS_RST) |=> (state_r == ST_SYS_RST || state_r == ST_BOOT)) // (R5)
        else $error("System reset hold left early");
    // (R6) boot then run
    AST_SYS_BOOT: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        boot_start_o |=> (state_r == ST_RUN && core_rst_n_o == !ctl_r[CTL_CORE_BIT])) // (R6)
        else $error("Boot not followed by run");
    // (R6) boot is one pulse
    AST_BOOT_PULSE: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        boot_start_o |=> !boot_start_o) // (R6)
        else $error("Boot pulse longer than one cycle");
    // (R8) control contents kept
    AST_SYS_KEEP: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        (state_r == ST_SYS_RST && !ctl_wr_i) |=> $stable(ctl_r)) // (R8)
        else $error("Control unit lost contents in system reset");
    // (R9) core bit holds core
    AST_CORE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        ctl_r[CTL_CORE_BIT] |-> !core_rst_n_o) // (R9)
        else $error("Core not held by control bit");
    // (R7) hardware reset clears control register and loads cause CAUSE_HW
    AST_HW_CLEAR: assert property (@(posedge sys_clk_i)
        $rose(hw_reset_n) |-> (ctl_r == CTL_RESET && cause_r == CAUSE_HW)) // (R7)
        else $error("Hardware reset left state");
    // (R10) low pin forces reset
    AST_PIN_LOW: assert property (@(posedge sys_clk_i)
        !hw_reset_n |-> (!sys_rst_n_o && regulator_wake_o == 1'b0)) // (R10)
        else $error("Hardware reset pin not obeyed");

    COV_HIB: cover property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        state_r == ST_RUN ##1 state_r == ST_HIBERNATE);
    COV_SYS: cover property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        state_r == ST_SYS_RST ##8 boot_start_o);
    COV_CORE: cover property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        state_r == ST_RUN && !core_rst_n_o);
    COV_HW_BOOT: cover property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        $rose(hw_reset_n) ##8 boot_start_o);
    COV_PRIO: cover property (@(posedge sys_clk_i) disable iff (!hw_reset_n)
        state_r == ST_RUN && hib_req_i && sys_req ##1 state_r == ST_HIBERNATE);
endmodule

/* logic/rst_seq_pkg.sv */
// Package of constants and types for the reset and hibernate sequencer
package rst_seq_pkg;
    // Cycles of stretch applied to hardware and system reset release
    localparam int unsigned RELEASE_HOLD = 8;
    localparam int unsigned HOLD_W       = 4;
    localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;
    localparam logic [HOLD_W-1:0] HOLD_LAST = 4'(RELEASE_HOLD - 1);
    // Reset control register layout
    localparam int unsigned CTL_W        = 4;
    localparam int unsigned CTL_SYS_BIT  = 0;
    localparam int unsigned CTL_CORE_BIT = 1;
    localparam logic [CTL_W-1:0] CTL_RESET = 4'h0;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_HW   = 2'h1;
    localparam logic [1:0] CAUSE_SYS  = 2'h2;
    localparam logic [1:0] CAUSE_HIB  = 2'h3;

    typedef enum logic [2:0] {
        ST_HW_RST,
        ST_SYS_RST,
        ST_BOOT,
        ST_RUN,
        ST_HIBERNATE
    } seq_state_t;
endpackage

/* logic/rst_sync.sv */
// Reset synchroniser: asserts asynchronously, releases on the clock
module rst_sync (
    // Clock and raw reset
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    // Synchronised reset
    output logic      rst_sync_n_o
);
    logic meta_r;
    logic sync_r;
    logic meta_nxt;
    logic sync_nxt;

    always_comb begin
        meta_nxt = 1'b1;
        sync_nxt = meta_r;
    end

    // (R14) async assert, sync release
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign rst_sync_n_o = sync_r;
endmodule

/* tb/core_regulator_model.sv */
// Behavioural model of the external core regulator
module core_regulator_model #(
    parameter int unsigned RAMP = 3
) (
    // Clock and wake request
    input  wire logic sys_clk_i,
    input  wire logic regulator_wake_i,
    // Core supply good
    output logic      core_pwr_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned ramp_cnt;
    always @(posedge sys_clk_i or negedge regulator_wake_i) begin
        if (!regulator_wake_i) begin
            ramp_cnt      <= 0;
            core_pwr_ok_o <= 1'b0;
        end else if (ramp_cnt < RAMP) begin
            ramp_cnt <= ramp_cnt + 1;
        end else begin
            core_pwr_ok_o <= 1'b1;
        end
    end
endmodule

/* tb/reset_hibernate_sequencer_tb.sv */
// Self-checking bench of the reset and hibernate sequencer
module reset_hibernate_sequencer_tb;
    import rst_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, wr, hib, ev, tr, emu, srst_n, crst_n, clk_en, boot, wake, pwr_ok;
    logic [3:0] wdata, reg_q, v;
    logic [7:0] keep, oe;
    logic [1:0] cause;
    int         miscompares, n_compared, n, cyc;
    int         seed = 32'h62af8e0e;

    reset_hibernate_sequencer i_reset_hibernate_sequencer (.sys_clk_i(clk), .rst_n_i(rst_n),
        .ctl_wr_i(wr), .ctl_wdata_i(wdata), .reset_ctrl_reg_o(reg_q), .hib_req_i(hib),
        .sys_event_ctrl_req_i(ev), .trigger_router_req_i(tr), .emu_req_i(emu),
        .pin_keep_i(keep), .pin_oe_allow_o(oe), .sys_rst_n_o(srst_n), .core_rst_n_o(crst_n),
        .clk_en_o(clk_en), .boot_start_o(boot), .regulator_wake_o(wake), .last_cause_o(cause));
    core_regulator_model i_core_regulator_model (.sys_clk_i(clk), .regulator_wake_i(wake),
        .core_pwr_ok_o(pwr_ok));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic exp_core(input logic [3:0] d);
        return !d[CTL_CORE_BIT];
    endfunction

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wait_boot();
        n = 0;
        while (boot !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("boot", 8'(n < 40), 8'h1);
        check("wake", 8'(wake), 8'h1);
        check("power", 8'(pwr_ok), 8'h1);
        check("clk_en", 8'(clk_en), 8'h1);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        {rst_n, wr, hib, ev, tr, emu, wdata, keep} = '0;
        repeat (8) @(posedge clk);
        #1;
        check("srst", 8'(srst_n), 8'h0);
        check("crst", 8'(crst_n), 8'h0);
        check("reg", 8'(reg_q), 8'h0);
        check("cause", 8'(cause), 8'(CAUSE_HW));
        @(posedge clk) rst_n <= 1'b1;
        wait_boot();
        for (int k = 0; k < 6; k++) begin
            v = 4'($random(seed)) & 4'he;
            @(posedge clk) {wr, wdata} <= {1'b1, (k == 5) ? 4'h0 : v};
            @(posedge clk) wr <= 1'b0;
            #1;
            check("reg", 8'(reg_q), 8'((k == 5) ? 4'h0 : v));
            check("core", 8'(crst_n), 8'(exp_core((k == 5) ? 4'h0 : v)));
        end
        for (int i = 0; i < 4; i++) begin
            v = 4'($random(seed)) & 4'hc;
            @(posedge clk) {wr, wdata, ev, tr, emu} <= {i == 0, 4'h1, i == 1, i == 2, i == 3};
            @(posedge clk) {wr, wdata, ev, tr, emu} <= {1'b1, v, 3'h0};
            #1;
            check("sys", 8'(srst_n), 8'h0);
            @(posedge clk) wr <= 1'b0;
            #1;
            check("core", 8'(crst_n), 8'h0);
            n = 1;
            while (srst_n === 1'b0 && n < 20) begin
                @(posedge clk);
                #1;
                n++;
            end
            check("hold", 8'(n), 8'(RELEASE_HOLD));
            check("boot", 8'(boot), 8'h1);
            check("cause", 8'(cause), 8'(CAUSE_SYS));
            check("reg", 8'(reg_q), 8'(v));
        end
        @(posedge clk) {hib, ev, keep} <= {2'h3, 8'($random(seed))};
        @(posedge clk) {hib, ev} <= 2'h0;
        #1;
        check("wake", 8'(wake), 8'h0);
        check("clk_en", 8'(clk_en), 8'h0);
        check("srst", 8'(srst_n), 8'h0);
        check("oe", oe, keep);
        repeat (4) @(posedge clk);
        #1;
        check("power", 8'(pwr_ok), 8'h0);
        check("cause", 8'(cause), 8'(CAUSE_HIB));
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("wake", 8'(wake), 8'h0);
        check("reg", 8'(reg_q), 8'h0);
        check("cause", 8'(cause), 8'(CAUSE_HW));
        @(posedge clk) rst_n <= 1'b1;
        wait_boot();
        check("oe", oe, 8'hff);
        @(posedge clk);
        #3 rst_n = 1'b0;
        #1 check("async", 8'(srst_n), 8'h0);
        @(posedge clk) rst_n <= 1'b1;
        wait_boot();
        stop_test();
    end
endmodule
